/* src/fbs_cmd_event.sv */
// What this block does
// RL1: Default mode: a double command needs both coil bits in one multi-coil write.
// RL2: Alternative mode: single-coil or multi-coil writes each switch a double command.
// RL3: Double-command mode resets to zero, both-coils-at-once.
// RL4: Detect stale offered data caused by processing overload as data-invalid.
// RL5: Default option: data-invalid bit set in diagnostic word, subfunction 2 and register 129.
// RL6: Exception option: coil, discrete and holding reads answer busy exception 06.
// RL7: Exception option still keeps the data-invalid bit readable through subfunction 2.
// RL8: Exception option keeps input-register reads and coil writes served normally.
// RL9: Data-invalid reporting selection resets to zero, the diagnostic bit.
// RL10: Event recorder depth is configurable from 10 to 1000 entries.
// RL11: When full, a new event replaces the oldest, first-in first-out.
// RL12: An overwrite sets an overflow flag reported with the next retrieval.
// RL13: Event recorder depth resets to 500 entries.
// RL14: At start-up a general scan refreshes the whole bus data copy.
// RL15: With start-up recording on, scanned start-up values enter the recorder.
// RL16: Each start-up recorded entry carries an extra general-scan flag.
// RL17: Start-up recording option resets to zero, disabled.
// RL18: With cause recording on, every message cause is recorded, changed or not.
// RL19: With cause recording off, only value-changing events are recorded.
// RL20: Cause recording option resets to zero, disabled.
// RL21: Entries leave oldest first; overflow clears once reported in a retrieval.
`timescale 1ns/100ps
`default_nettype none

module fbs_cmd_event (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [fbs_pkg::REG_AW-1:0] reg_addr,
  input wire logic [fbs_pkg::REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output var logic [fbs_pkg::REG_DW-1:0] reg_rdata_r,
  input wire fbs_pkg::fbs_req_t req,
  output var fbs_pkg::fbs_rsp_t rsp_r,
  output var fbs_pkg::fbs_cmd_t cmd_r,
  input wire logic data_overload,
  input wire fbs_pkg::fbs_evt_t evt,
  output var logic scan_req_r,
  input wire logic scan_done
);
  import fbs_pkg::*;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [CFG_W-1:0] cfg_r;
  logic [DEPTH_W-1:0] depth_r;
  logic invalid_r;
  logic cfg_wr;
  logic depth_wr;
  logic double_cmd_single_coil_allow;
  logic invalid_data_report_select;
  logic event_log_startup_scan_record;
  logic event_log_cause_record;

  assign cfg_wr = reg_wr && (reg_addr == ADDR_CONFIG);
  assign depth_wr = reg_wr && (reg_addr == ADDR_DEPTH);
  assign double_cmd_single_coil_allow = cfg_r[CFG_SINGLE_COIL_BIT];
  assign invalid_data_report_select = cfg_r[CFG_REPORT_EXC_BIT];
  assign event_log_startup_scan_record = cfg_r[CFG_STARTUP_REC_BIT];
  assign event_log_cause_record = cfg_r[CFG_CAUSE_REC_BIT];

  // Out-of-range depth writes are pulled to the nearest limit.
  function automatic logic [DEPTH_W-1:0] clamp_depth(input logic [REG_DW-1:0] v);
    logic [DEPTH_W-1:0] d;
    d = DEPTH_MAX;
    if (v < REG_DW'(DEPTH_MIN))
      d = DEPTH_MIN;
    else if (v <= REG_DW'(DEPTH_MAX))
      d = v[DEPTH_W-1:0];
    return d;
  endfunction

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      cfg_r <= CFG_RESET; // [RL3] [RL9] [RL17] [RL20]
    else if (cfg_wr)
      cfg_r <= reg_wdata[CFG_W-1:0];
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      depth_r <= DEPTH_RESET; // [RL13]
    else if (depth_wr)
      depth_r <= clamp_depth(reg_wdata); // [RL10]
  end

  // The overload indication comes from the host-side data copy logic.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      invalid_r <= 1'b0;
    else
      invalid_r <= data_overload; // [RL4]
  end

  logic [15:0] diag_word;
  always_comb
  begin
    diag_word = '0;
    diag_word[DIAG_INVALID_BIT] = invalid_r; // [RL5] [RL7]
  end

  // ---------------------------------------------------------------
  // Request decoding
  // ---------------------------------------------------------------
  // One coil of a pair written alone: the ON coil set switches on,
  // the OFF coil set switches off, a cleared coil gives no command.
  function automatic fbs_cmd_t single_coil(input fbs_req_t r);
    fbs_cmd_t c;
    c = '0;
    c.idx = r.cmd_idx;
    if (r.coil_mask[COIL_ON_BIT] && r.coil_val[COIL_ON_BIT])
    begin
      c.valid = 1'b1;
      c.on = 1'b1;
    end
    else if (r.coil_mask[COIL_OFF_BIT] && r.coil_val[COIL_OFF_BIT])
    begin
      c.valid = 1'b1;
      c.on = 1'b0;
    end
    return c;
  endfunction

  fbs_rsp_t rsp_nxt;
  fbs_cmd_t cmd_nxt;
  logic busy_block;

  assign busy_block = invalid_data_report_select && invalid_r; // [RL6]

  always_comb
  begin
    rsp_nxt = '0;
    cmd_nxt = '0;
    if (req.valid)
    begin
      rsp_nxt.valid = 1'b1;
      unique case (req.func)
        FC_READ_COILS, FC_READ_DISCRETE, FC_READ_HOLDING:
        begin
          if (busy_block)
            rsp_nxt.exc = EXC_BUSY; // [RL6]
          else if (req.func == FC_READ_HOLDING && req.addr == HOLD_DIAG_ADDR)
          begin
            rsp_nxt.has_data = 1'b1;
            rsp_nxt.data = diag_word; // [RL5]
          end
          else
            rsp_nxt.serve = 1'b1;
        end
        FC_READ_INPUT:
          rsp_nxt.serve = 1'b1; // [RL8]
        FC_DIAG:
        begin
          if (req.sub == DIAG_SUB_REGISTER)
          begin
            rsp_nxt.has_data = 1'b1;
            rsp_nxt.data = diag_word; // [RL5] [RL7]
          end
          else
            rsp_nxt.serve = 1'b1;
        end
        FC_WRITE_COIL:
        begin
          if (double_cmd_single_coil_allow)
            cmd_nxt = single_coil(req); // [RL2] [RL8]
          else
            rsp_nxt.exc = EXC_ILLEGAL_VALUE; // [RL1]
        end
        FC_WRITE_COILS:
        begin
          if (req.coil_mask == COIL_BOTH)
          begin
            // Both coils at once: exactly one of them must be set.
            if (req.coil_val[COIL_ON_BIT] != req.coil_val[COIL_OFF_BIT])
            begin
              cmd_nxt.valid = 1'b1; // [RL1] [RL8]
              cmd_nxt.idx = req.cmd_idx;
              cmd_nxt.on = req.coil_val[COIL_ON_BIT];
            end
            else
              rsp_nxt.exc = EXC_ILLEGAL_VALUE;
          end
          else if (double_cmd_single_coil_allow)
            cmd_nxt = single_coil(req); // [RL2]
          else
            rsp_nxt.exc = EXC_ILLEGAL_VALUE; // [RL1]
        end
        default:
          rsp_nxt.serve = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      rsp_r <= '0;
    else
      rsp_r <= rsp_nxt;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      cmd_r <= '0;
    else
      cmd_r <= cmd_nxt;
  end

  // ---------------------------------------------------------------
  // Start-up general scan
  // ---------------------------------------------------------------
  fbs_state_t state_r;
  logic scanning;

  assign scanning = (state_r != ST_RUN);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      state_r <= ST_SCAN_REQ;
    else
    begin
      unique case (state_r)
        ST_SCAN_REQ:
          state_r <= ST_SCAN_WAIT; // [RL14]
        ST_SCAN_WAIT:
          if (scan_done)
            state_r <= ST_RUN;
        ST_RUN:
          state_r <= ST_RUN;
        default:
          state_r <= ST_SCAN_REQ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      scan_req_r <= 1'b0;
    else
      scan_req_r <= (state_r == ST_SCAN_REQ); // [RL14]
  end

  // ---------------------------------------------------------------
  // Event recorder
  // ---------------------------------------------------------------
  // The store always has room for the largest depth; the depth setting
  // only limits how many entries are kept, so changing it never moves data.
  fbs_entry_t mem [MEM_DEPTH];
  logic [DEPTH_W-1:0] wr_ptr_r;
  logic [DEPTH_W-1:0] rd_ptr_r;
  logic [DEPTH_W-1:0] count_r;
  logic ovf_r;
  logic push;
  logic pop;
  logic full;
  logic overwrite;
  fbs_entry_t head;
  fbs_entry_t new_entry;

  // During the scan only start-up values arrive; afterwards filter by cause.
  assign push = evt.valid &&
    (scanning ? event_log_startup_scan_record // [RL15]
              : (evt.changed || event_log_cause_record)); // [RL18] [RL19]
  assign pop = reg_rd && (reg_addr == ADDR_EVT_POP) && (count_r != '0);
  assign full = (count_r >= depth_r);
  assign overwrite = push && full && !pop; // [RL11]
  assign head = mem[rd_ptr_r];

  always_comb
  begin
    new_entry.gs = scanning; // [RL16]
    new_entry.cause = evt.cause;
    new_entry.data = evt.data;
  end

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wr_ptr_r] <= new_entry;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      wr_ptr_r <= '0;
    else if (push)
      wr_ptr_r <= wr_ptr_r + PTR_STEP;
  end

  // Oldest entry leaves on a retrieval or is dropped on an overwrite.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      rd_ptr_r <= '0;
    else if (pop || overwrite)
      rd_ptr_r <= rd_ptr_r + PTR_STEP; // [RL11] [RL21]
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      count_r <= '0;
    else if (push && !pop && !full)
      count_r <= count_r + PTR_STEP;
    else if (pop && !push)
      count_r <= count_r - PTR_STEP;
  end

  // A push in the reporting cycle is no overwrite, so the flag still clears.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      ovf_r <= 1'b0;
    else if (overwrite)
      ovf_r <= 1'b1; // [RL12]
    else if (pop)
      ovf_r <= 1'b0; // [RL21]
  end

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  logic [REG_DW-1:0] rdata_nxt;

  always_comb
  begin
    rdata_nxt = '0;
    unique case (reg_addr)
      ADDR_CONFIG:
        rdata_nxt[CFG_W-1:0] = cfg_r;
      ADDR_DEPTH:
        rdata_nxt[DEPTH_W-1:0] = depth_r;
      ADDR_DIAG:
        rdata_nxt[15:0] = diag_word;
      ADDR_COUNT:
        rdata_nxt[DEPTH_W-1:0] = count_r;
      ADDR_EVT_POP:
      begin
        rdata_nxt[POP_OVF_BIT] = ovf_r; // [RL12]
        if (count_r != '0)
        begin
          rdata_nxt[POP_VALID_BIT] = 1'b1; // [RL21]
          rdata_nxt[POP_GS_BIT] = head.gs; // [RL16]
          rdata_nxt[POP_CAUSE_BIT] = head.cause;
          rdata_nxt[15:0] = head.data;
        end
      end
      default:
        rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata_r <= '0;
    else if (reg_rd)
      reg_rdata_r <= rdata_nxt;
    else
      reg_rdata_r <= '0;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  chk_busy_read_exc: assert property ( // [RL6]
    req.valid && req.func == FC_READ_HOLDING && invalid_data_report_select && invalid_r
    |=> rsp_r.valid && rsp_r.exc == EXC_BUSY && !rsp_r.serve)
    else $error("holding read while invalid did not answer busy");

  chk_input_read_served: assert property ( // [RL8]
    req.valid && req.func == FC_READ_INPUT |=> rsp_r.serve && rsp_r.exc == EXC_NONE)
    else $error("input register read not served");

  chk_single_coil_block: assert property ( // [RL1]
    req.valid && req.func == FC_WRITE_COIL && !double_cmd_single_coil_allow
    |=> !cmd_r.valid && rsp_r.exc == EXC_ILLEGAL_VALUE)
    else $error("single coil write accepted in both-coils mode");

  chk_single_coil_on: assert property ( // [RL2]
    req.valid && req.func == FC_WRITE_COIL && double_cmd_single_coil_allow &&
    req.coil_mask[COIL_ON_BIT] && req.coil_val[COIL_ON_BIT]
    |=> cmd_r.valid && cmd_r.on && cmd_r.idx == $past(req.cmd_idx))
    else $error("single ON coil write gave no on command");

  chk_diag_word: assert property ( // [RL7]
    req.valid && req.func == FC_DIAG && req.sub == DIAG_SUB_REGISTER
    |=> rsp_r.has_data && rsp_r.data[DIAG_INVALID_BIT] == $past(invalid_r))
    else $error("diagnostic word lost the data-invalid bit");

  chk_depth_range: assert property ( // [RL10]
    depth_r >= DEPTH_MIN && depth_r <= DEPTH_MAX)
    else $error("recorder depth outside its range");

  chk_overwrite_count: assert property ( // [RL11]
    overwrite |=> count_r == $past(count_r) && rd_ptr_r == $past(rd_ptr_r) + PTR_STEP)
    else $error("overwrite did not drop the oldest entry");

  chk_overflow_set: assert property ( // [RL12]
    overwrite |=> ovf_r)
    else $error("overflow flag not set on overwrite");

  chk_overflow_clear: assert property ( // [RL21]
    pop |=> !ovf_r ##1 reg_rdata_r == '0 || $past(reg_rd))
    else $error("overflow flag not cleared after retrieval");

  chk_scan_pulse: assert property ( // [RL14]
    arst_n && state_r == ST_SCAN_REQ |=> scan_req_r ##1 !scan_req_r)
    else $error("start-up scan request is not a single pulse");

  chk_no_change_skip: assert property ( // [RL19]
    evt.valid && !evt.changed && !event_log_cause_record && !scanning
    |=> wr_ptr_r == $past(wr_ptr_r))
    else $error("unchanged event recorded with cause recording off");

endmodule

`default_nettype wire

/* src/fbs_pkg.sv */
package fbs_pkg;

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  localparam int unsigned REG_AW = 8;
  localparam int unsigned REG_DW = 32;
  localparam logic [REG_AW-1:0] ADDR_CONFIG = 8'h00;
  localparam logic [REG_AW-1:0] ADDR_DEPTH = 8'h01;
  localparam logic [REG_AW-1:0] ADDR_DIAG = 8'h02;
  localparam logic [REG_AW-1:0] ADDR_COUNT = 8'h03;
  localparam logic [REG_AW-1:0] ADDR_EVT_POP = 8'h04;

  // Configuration word fields.
  localparam int unsigned CFG_W = 4;
  localparam int unsigned CFG_SINGLE_COIL_BIT = 0;
  localparam int unsigned CFG_REPORT_EXC_BIT = 1;
  localparam int unsigned CFG_STARTUP_REC_BIT = 2;
  localparam int unsigned CFG_CAUSE_REC_BIT = 3;
  localparam logic [CFG_W-1:0] CFG_RESET = 4'h0;

  // Event recorder depth.
  localparam int unsigned DEPTH_W = 10;
  localparam int unsigned MEM_DEPTH = 1024;
  localparam logic [DEPTH_W-1:0] DEPTH_MIN = 10'h00A;
  localparam logic [DEPTH_W-1:0] DEPTH_MAX = 10'h3E8;
  localparam logic [DEPTH_W-1:0] DEPTH_RESET = 10'h1F4;
  localparam logic [DEPTH_W-1:0] PTR_STEP = 10'h001;

  // Event retrieval word fields.
  localparam int unsigned POP_CAUSE_BIT = 16;
  localparam int unsigned POP_GS_BIT = 17;
  localparam int unsigned POP_OVF_BIT = 18;
  localparam int unsigned POP_VALID_BIT = 19;

  // ---------------------------------------------------------------
  // Fieldbus functions and answers
  // ---------------------------------------------------------------
  localparam logic [7:0] FC_READ_COILS = 8'h01;
  localparam logic [7:0] FC_READ_DISCRETE = 8'h02;
  localparam logic [7:0] FC_READ_HOLDING = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_WRITE_COIL = 8'h05;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_WRITE_COILS = 8'h0F;
  localparam logic [15:0] DIAG_SUB_REGISTER = 16'h0002;
  localparam logic [15:0] HOLD_DIAG_ADDR = 16'h0081;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
  localparam logic [7:0] EXC_BUSY = 8'h06;
  // Position of the data-invalid flag in the diagnostic word; arbitrary.
  localparam int unsigned DIAG_INVALID_BIT = 0;
  localparam int unsigned COIL_ON_BIT = 0;
  localparam int unsigned COIL_OFF_BIT = 1;
  localparam logic [1:0] COIL_BOTH = 2'h3;

  typedef struct packed {
    logic valid;
    logic [7:0] func;
    logic [15:0] sub;
    logic [15:0] addr;
    logic [7:0] cmd_idx;
    logic [1:0] coil_mask;
    logic [1:0] coil_val;
  } fbs_req_t;

  typedef struct packed {
    logic valid;
    logic serve;
    logic has_data;
    logic [7:0] exc;
    logic [15:0] data;
  } fbs_rsp_t;

  typedef struct packed {
    logic valid;
    logic [7:0] idx;
    logic on;
  } fbs_cmd_t;

  typedef struct packed {
    logic valid;
    logic changed;
    logic cause;
    logic [15:0] data;
  } fbs_evt_t;

  typedef struct packed {
    logic gs;
    logic cause;
    logic [15:0] data;
  } fbs_entry_t;

  typedef enum logic [2:0] {
    ST_SCAN_REQ = 3'b001,
    ST_SCAN_WAIT = 3'b010,
    ST_RUN = 3'b100
  } fbs_state_t;

endpackage

/* testbench/fbs_master_model.sv */
`timescale 1ns/100ps
`default_nettype none

module fbs_master_model (
  input wire logic mclk,
  output var fbs_pkg::fbs_req_t req,
  input wire fbs_pkg::fbs_rsp_t rsp_r,
  input wire fbs_pkg::fbs_cmd_t cmd_r
);
  import fbs_pkg::*;

  initial req = '0;

  // ---------------------------------------------------------------
  // Request issue
  // ---------------------------------------------------------------
  // Both coils of a pair travel in one request when the caller sets mask 11.
  // Fields are inverted once released, so a design cannot lean on stale values.
  task automatic issue(input logic [7:0] f, input logic [15:0] a, input logic [7:0] idx,
                       input logic [1:0] m, input logic [1:0] v,
                       output fbs_rsp_t r, output fbs_cmd_t c);
    fbs_req_t q;
    fbs_req_t q2;
    q = '{valid: 1'b1, func: f, sub: a, addr: a, cmd_idx: idx, coil_mask: m, coil_val: v};
    q2 = ~q;
    q2.valid = 1'b0;
    @(posedge mclk);
    req <= q;
    @(posedge mclk);
    req <= q2;
    @(posedge mclk);
    r = rsp_r;
    c = cmd_r;
  endtask
endmodule

`default_nettype wire

/* testbench/fbs_cmd_event_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module fbs_cmd_event_tb;
  import fbs_pkg::*;

  logic mclk;
  logic arst_n;
  logic reg_wr;
  logic reg_rd;
  logic data_overload;
  logic scan_done;
  logic scan_req_r;
  logic [REG_AW-1:0] reg_addr;
  logic [REG_DW-1:0] reg_wdata;
  logic [REG_DW-1:0] reg_rdata_r;
  logic [REG_DW-1:0] rv;
  logic [15:0] d0;
  logic [15:0] d1;
  logic [15:0] pushed[$];
  fbs_req_t req;
  fbs_rsp_t rsp_r;
  fbs_rsp_t r;
  fbs_cmd_t cmd_r;
  fbs_evt_t evt;
  int n_fail;
  int n_checks;

  fbs_cmd_event fbs_cmd_event_inst (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
    .req(req), .rsp_r(rsp_r), .cmd_r(cmd_r), .data_overload(data_overload), .evt(evt),
    .scan_req_r(scan_req_r), .scan_done(scan_done));

  fbs_master_model fbs_master_model_inst (.mclk(mclk), .req(req), .rsp_r(rsp_r),
    .cmd_r(cmd_r));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    d = reg_rdata_r;
  endtask

  task automatic push(input logic ch, input logic ca, input logic [15:0] d);
    @(posedge mclk);
    evt <= '{valid: 1'b1, changed: ch, cause: ca, data: d};
    @(posedge mclk);
    evt <= '{valid: 1'b0, changed: ~ch, cause: ~ca, data: ~d};
  endtask

  // Expected retrieval word for one stored entry.
  function automatic logic [31:0] ent(logic ovf, logic gs, logic ca, logic [15:0] d);
    return {12'h000, 1'b1, ovf, gs, ca, d};
  endfunction

  task automatic rq(input logic [7:0] f, input logic [15:0] a, input logic [1:0] m,
                    input logic [1:0] v, input logic [7:0] exc, input logic cv,
                    input logic on);
    logic [7:0] idx;
    fbs_cmd_t c;
    idx = 8'($urandom);
    fbs_master_model_inst.issue(f, a, idx, m, v, r, c);
    check({r.valid, r.exc, c.valid}, {1'b1, exc, cv});
    if (cv)
      check({c.on, c.idx}, {on, idx});
  endtask

  // ---------------------------------------------------------------
  // Clock and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    print_verdict();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    data_overload = 1'b0;
    scan_done = 1'b0;
    evt = '0;
    n_fail = 0;
    n_checks = 0;
    void'($urandom(32'h190d));
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    for (int k = 0; k < 4 && scan_req_r !== 1'b1; k++)
      @(posedge mclk);
    check(scan_req_r, 1);
    rd(ADDR_CONFIG, rv);
    check(rv, 0);
    rd(ADDR_DEPTH, rv);
    check(rv, 500);
    // Start-up values are only kept when the option is on before the scan ends.
    wr(ADDR_CONFIG, 32'h4);
    d0 = 16'($urandom);
    d1 = 16'($urandom);
    push(1'b0, 1'b0, d0);
    push(1'b1, 1'b0, d1);
    @(posedge mclk);
    scan_done <= 1'b1;
    @(posedge mclk);
    scan_done <= 1'b0;
    rd(ADDR_COUNT, rv);
    check(rv, 2);
    rd(ADDR_EVT_POP, rv);
    check(rv, ent(0, 1, 0, d0));
    rd(ADDR_EVT_POP, rv);
    check(rv, ent(0, 1, 0, d1));
    wr(ADDR_CONFIG, 32'h0);
    push(1'b0, 1'b1, d0);
    rd(ADDR_COUNT, rv);
    check(rv, 0);
    push(1'b1, 1'b0, d0);
    wr(ADDR_CONFIG, 32'h8);
    push(1'b0, 1'b1, d1);
    rd(ADDR_COUNT, rv);
    check(rv, 2);
    rd(ADDR_EVT_POP, rv);
    check(rv, ent(0, 0, 0, d0));
    rd(ADDR_EVT_POP, rv);
    check(rv, ent(0, 0, 1, d1));
    wr(ADDR_DEPTH, 32'd5);
    rd(ADDR_DEPTH, rv);
    check(rv, 10);
    wr(ADDR_DEPTH, 32'd1001);
    rd(ADDR_DEPTH, rv);
    check(rv, 1000);
    wr(ADDR_DEPTH, 32'd10);
    wr(ADDR_CONFIG, 32'h0);
    for (int k = 0; k < 12; k++)
    begin
      pushed.push_back(16'($urandom));
      push(1'b1, 1'b0, pushed[k]);
    end
    rd(ADDR_COUNT, rv);
    check(rv, 10);
    for (int k = 2; k < 12; k++)
    begin
      rd(ADDR_EVT_POP, rv);
      check(rv, ent(k == 2, 0, 0, pushed[k]));
    end
    rd(ADDR_EVT_POP, rv);
    check(rv[POP_VALID_BIT], 0);
    rq(FC_WRITE_COILS, 0, 2'h3, 2'h1, EXC_NONE, 1, 1);
    rq(FC_WRITE_COILS, 0, 2'h3, 2'h2, EXC_NONE, 1, 0);
    rq(FC_WRITE_COILS, 0, 2'h3, 2'h0, EXC_ILLEGAL_VALUE, 0, 0);
    rq(FC_WRITE_COILS, 0, 2'h3, 2'h3, EXC_ILLEGAL_VALUE, 0, 0);
    rq(FC_WRITE_COILS, 0, 2'h1, 2'h1, EXC_ILLEGAL_VALUE, 0, 0);
    rq(FC_WRITE_COIL, 0, 2'h1, 2'h1, EXC_ILLEGAL_VALUE, 0, 0);
    wr(ADDR_CONFIG, 32'h1);
    rq(FC_WRITE_COIL, 0, 2'h1, 2'h1, EXC_NONE, 1, 1);
    rq(FC_WRITE_COIL, 0, 2'h2, 2'h2, EXC_NONE, 1, 0);
    rq(FC_WRITE_COILS, 0, 2'h3, 2'h1, EXC_NONE, 1, 1);
    wr(ADDR_CONFIG, 32'h0);
    data_overload <= 1'b1;
    repeat (2) @(posedge mclk);
    rq(FC_READ_HOLDING, HOLD_DIAG_ADDR, 0, 0, EXC_NONE, 0, 0);
    check({r.has_data, r.data[DIAG_INVALID_BIT]}, 2'h3);
    rq(FC_DIAG, DIAG_SUB_REGISTER, 0, 0, EXC_NONE, 0, 0);
    check({r.has_data, r.data[DIAG_INVALID_BIT]}, 2'h3);
    rd(ADDR_DIAG, rv);
    check(rv[DIAG_INVALID_BIT], 1);
    rq(FC_READ_COILS, 0, 0, 0, EXC_NONE, 0, 0);
    wr(ADDR_CONFIG, 32'h2);
    rq(FC_READ_COILS, 0, 0, 0, EXC_BUSY, 0, 0);
    rq(FC_READ_DISCRETE, 0, 0, 0, EXC_BUSY, 0, 0);
    rq(FC_READ_HOLDING, 0, 0, 0, EXC_BUSY, 0, 0);
    rq(FC_READ_INPUT, 0, 0, 0, EXC_NONE, 0, 0);
    check(r.serve, 1);
    rq(FC_WRITE_COILS, 0, 2'h3, 2'h2, EXC_NONE, 1, 0);
    rq(FC_DIAG, DIAG_SUB_REGISTER, 0, 0, EXC_NONE, 0, 0);
    check({r.has_data, r.data[DIAG_INVALID_BIT]}, 2'h3);
    data_overload <= 1'b0;
    repeat (2) @(posedge mclk);
    rq(FC_READ_HOLDING, 0, 0, 0, EXC_NONE, 0, 0);
    // A reset in mid-run repeats the scan, now with start-up recording off.
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    for (int k = 0; k < 4 && scan_req_r !== 1'b1; k++)
      @(posedge mclk);
    check(scan_req_r, 1);
    rd(ADDR_CONFIG, rv);
    check(rv, 0);
    rd(ADDR_COUNT, rv);
    check(rv, 0);
    push(1'b1, 1'b0, d0);
    @(posedge mclk);
    scan_done <= 1'b1;
    @(posedge mclk);
    scan_done <= 1'b0;
    push(1'b1, 1'b1, d1);
    rd(ADDR_COUNT, rv);
    check(rv, 1);
    rd(ADDR_EVT_POP, rv);
    check(rv, ent(0, 0, 1, d1));
    print_verdict();
  end
endmodule

`default_nettype wire
